// file: hw/trim_regs_pkg.sv
// trim_regs_pkg: constants and carrier types for the core offset/gain trim bank.
// assumes a 16-bit plain register port with byte addresses as printed offsets.
package trim_regs_pkg;

    // register port geometry
    localparam int unsigned ADDR_BITS = 12;
    localparam int unsigned DATA_BITS = 16;

    // offset trim registers, 16 bits wide
    localparam logic [11:0] ADDR_OFFSET_TRIM_CORE3_PAIR_C   = 12'h338;
    localparam logic [11:0] ADDR_OFFSET_TRIM_CORE3_PAIR_D   = 12'h33a;
    localparam logic [11:0] ADDR_OFFSET_TRIM_CORE4          = 12'h33c;
    localparam logic [11:0] ADDR_OFFSET_TRIM_CORE5          = 12'h33e;
    // fine gain trim registers, 8 bits wide
    localparam logic [11:0] ADDR_FINE_GAIN_CORE_ZERO        = 12'h360;
    localparam logic [11:0] ADDR_FINE_GAIN_CORE_ONE         = 12'h361;
    localparam logic [11:0] ADDR_FINE_GAIN_CORE_TWO_PAIR_A  = 12'h362;
    localparam logic [11:0] ADDR_FINE_GAIN_CORE_TWO_PAIR_B  = 12'h363;
    localparam logic [11:0] ADDR_FINE_GAIN_CORE_THREE_PAIR_C = 12'h364;
    localparam logic [11:0] ADDR_FINE_GAIN_CORE_THREE_PAIR_D = 12'h365;
    // block status, read only
    localparam logic [11:0] ADDR_TRIM_STATUS                = 12'h370;

    // field layout
    localparam int unsigned OFS_FIELD_MSB  = 11;
    localparam int unsigned OFS_REG_MSB    = 15;
    localparam int unsigned GAIN_FIELD_MSB = 4;
    localparam int unsigned GAIN_REG_MSB   = 7;
    localparam int unsigned STAT_LOADED_BIT = 0;
    localparam int unsigned STAT_SEL2_BIT   = 1;
    localparam int unsigned STAT_SEL3_BIT   = 2;

    // reset values before the fuse load replaces them
    localparam logic [15:0] OFS_RESET  = 16'h0000;
    localparam logic [7:0]  GAIN_RESET = 8'h00;

    // storage indices
    localparam int unsigned NUM_OFS  = 4;   // core3 pair c, core3 pair d, core4, core5
    localparam int unsigned NUM_GAIN = 6;   // core0, core1, core2 a/b, core3 c/d

    // load sequencer phases
    typedef enum logic {
        PH_LOAD = 1'b0,
        PH_RUN  = 1'b1
    } trim_phase_t;

    // defaults coming out of fuse storage
    typedef struct packed {
        logic [NUM_OFS-1:0][11:0] ofs;
        logic [NUM_GAIN-1:0][4:0] gain;
    } fuse_trim_t;

    // values applied to the sampling cores: ofs = core3,4,5 ; gain = core0..3
    typedef struct packed {
        logic [2:0][11:0] ofs;
        logic [3:0][4:0]  gain;
    } applied_trim_t;

    // result of an address decode
    typedef struct packed {
        logic       ofs_hit;
        logic       gain_hit;
        logic       stat_hit;
        logic [2:0] idx;
    } trim_decode_t;

endpackage

// file: hw/core_offset_gain_trim_regs.sv
// core_offset_gain_trim_regs: trim register bank and per-core trim selection.
// assumes synchronous port inputs, one strobe per cycle, and fuse data stable
// from reset release on; software stays off the offset trims during offset cal.
//
// Functional notes
// [R01] offset trim is 12 bits, drives its core
// [R02] core3 offset follows the sampled input pair
// [R03] software writes reserved upper bits as zero
// [R04] fine gain trim is 5 bits, drives core
// [R05] core2 gain follows its sampled input pair
// [R06] core3 gain follows its sampled input pair
// [R07] defaults load from fuse storage after reset
// [R08] offset trim field is an unsigned number
// [R09] no offset access during offset calibration
// [R10] written trims take effect within cycles, no reset
//
// timing summary for whoever integrates this bank:
// - the fuse copy runs in the single cycle after reset release; a strobe
//   given in that cycle is dropped, so the first access waits one more edge
// - a write lands in storage at its strobe edge and reaches the cores one
//   edge later; the extra register keeps the core trims glitch free
// - a pair select change reaches the cores at the same edge that samples it
// - reserved bits are stored and read back as written but never applied;
//   keeping them writable costs 4 flops per offset and 3 per gain slot
// - the block cannot tell when offset calibration runs, so keeping software
//   away from the offset trims at that time is left to the caller
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps

module core_offset_gain_trim_regs
    import trim_regs_pkg::*;
#(
    parameter int unsigned ADDR_W = ADDR_BITS   // register port address width
) (
    input  wire logic                 clk_sys_in,          // 200 MHz system clock
    input  wire logic                 rst_b_in,            // async reset, active low
    input  wire logic [ADDR_W-1:0]    addr_in,             // register byte address
    input  wire logic [DATA_BITS-1:0] wdata_in,            // write data
    input  wire logic                 wr_in,               // write strobe
    input  wire logic                 rd_in,               // read strobe
    output logic      [DATA_BITS-1:0] rdata_out,           // read data, cycle after rd
    input  wire fuse_trim_t           fuse_in,             // fuse default values
    input  wire logic                 core2_pair_b_sel_in, // core2 samples input_pair_b
    input  wire logic                 core3_pair_d_sel_in, // core3 samples input_pair_d
    output applied_trim_t             applied_out          // trims applied to cores
);

    // the decode compares against 12-bit offsets, so narrower ports cannot reach them
    if (ADDR_W < ADDR_BITS) begin : g_addr_check
        $error("ADDR_W must be at least ADDR_BITS");
    end

    // whole state of the block
    typedef struct packed {
        trim_phase_t                  phase;   // fuse load or normal run
        logic [NUM_OFS-1:0][15:0]     ofs;     // offset trim storage
        logic [NUM_GAIN-1:0][7:0]     gain;    // fine gain trim storage
        applied_trim_t                applied; // registered per-core trims
        logic [DATA_BITS-1:0]         rdata;   // read return, one cycle
    } trim_state_t;

    trim_state_t  state_reg;   // current state
    trim_state_t  state_next;  // next state
    trim_decode_t dec;         // decode of the current address

    // map an address to a storage slot; unmapped gives no hit
    function automatic trim_decode_t decode_addr(input logic [ADDR_W-1:0] a);
        trim_decode_t d;
        d = '0;
        if (a == ADDR_W'(ADDR_OFFSET_TRIM_CORE3_PAIR_C)) begin
            d.ofs_hit = 1'b1;
            d.idx     = 3'h0;
        end else if (a == ADDR_W'(ADDR_OFFSET_TRIM_CORE3_PAIR_D)) begin
            d.ofs_hit = 1'b1;
            d.idx     = 3'h1;
        end else if (a == ADDR_W'(ADDR_OFFSET_TRIM_CORE4)) begin
            d.ofs_hit = 1'b1;
            d.idx     = 3'h2;
        end else if (a == ADDR_W'(ADDR_OFFSET_TRIM_CORE5)) begin
            d.ofs_hit = 1'b1;
            d.idx     = 3'h3;
        end else if (a == ADDR_W'(ADDR_FINE_GAIN_CORE_ZERO)) begin
            d.gain_hit = 1'b1;
            d.idx      = 3'h0;
        end else if (a == ADDR_W'(ADDR_FINE_GAIN_CORE_ONE)) begin
            d.gain_hit = 1'b1;
            d.idx      = 3'h1;
        end else if (a == ADDR_W'(ADDR_FINE_GAIN_CORE_TWO_PAIR_A)) begin
            d.gain_hit = 1'b1;
            d.idx      = 3'h2;
        end else if (a == ADDR_W'(ADDR_FINE_GAIN_CORE_TWO_PAIR_B)) begin
            d.gain_hit = 1'b1;
            d.idx      = 3'h3;
        end else if (a == ADDR_W'(ADDR_FINE_GAIN_CORE_THREE_PAIR_C)) begin
            d.gain_hit = 1'b1;
            d.idx      = 3'h4;
        end else if (a == ADDR_W'(ADDR_FINE_GAIN_CORE_THREE_PAIR_D)) begin
            d.gain_hit = 1'b1;
            d.idx      = 3'h5;
        end else if (a == ADDR_W'(ADDR_TRIM_STATUS)) begin
            d.stat_hit = 1'b1;
        end
        return d;
    endfunction

    // address decode shared by the write and read paths
    assign dec = decode_addr(addr_in);

    // next-state logic: fuse load, register access, trim selection
    // storage and the applied copy are updated in the same process so that
    // a write and a pair select change in one cycle never race each other
    always_comb begin
        state_next       = state_reg;
        state_next.rdata = '0;  // read data stands for one cycle only
        case (state_reg.phase)
            PH_LOAD: begin
                // first cycle after release: copy fuse defaults, reserved bits zero
                for (int i = 0; i < NUM_OFS; i++) begin
                    state_next.ofs[i] = {4'h0, fuse_in.ofs[i]};  // R07
                end
                for (int j = 0; j < NUM_GAIN; j++) begin
                    state_next.gain[j] = {3'h0, fuse_in.gain[j]};  // R07
                end
                // strobes in this cycle are dropped so the fuse copy is never torn
                state_next.phase = PH_RUN;
            end
            PH_RUN: begin
                // a write lands in the addressed slot, reserved bits kept as written
                if (wr_in) begin
                    if (dec.ofs_hit) begin
                        state_next.ofs[dec.idx[1:0]] = wdata_in;  // R10
                    end else if (dec.gain_hit) begin
                        state_next.gain[dec.idx] = wdata_in[GAIN_REG_MSB:0];  // R10
                    end
                end
                // a read returns the slot, narrower data zero extended
                if (rd_in) begin
                    if (dec.ofs_hit) begin
                        state_next.rdata = state_reg.ofs[dec.idx[1:0]];
                    end else if (dec.gain_hit) begin
                        state_next.rdata = {8'h00, state_reg.gain[dec.idx]};
                    end else if (dec.stat_hit) begin
                        state_next.rdata[STAT_LOADED_BIT] = 1'b1;
                        state_next.rdata[STAT_SEL2_BIT]   = core2_pair_b_sel_in;
                        state_next.rdata[STAT_SEL3_BIT]   = core3_pair_d_sel_in;
                    end
                    // unmapped addresses read as zero
                end
            end
            default: begin
                state_next.phase = PH_LOAD;
            end
        endcase

        // selection reads the stored value, not the write data, so a write
        // takes one extra edge to reach a core; the cores never see a value
        // that the bus is still presenting
        // core3 offset picks the pair it samples; unsigned, no sign extension
        state_next.applied.ofs[0] = core3_pair_d_sel_in ?
                                    state_reg.ofs[1][OFS_FIELD_MSB:0] :
                                    state_reg.ofs[0][OFS_FIELD_MSB:0];  // R02 R08
        state_next.applied.ofs[1] = state_reg.ofs[2][OFS_FIELD_MSB:0];   // R01 R08
        state_next.applied.ofs[2] = state_reg.ofs[3][OFS_FIELD_MSB:0];   // R01 R08
        // reserved upper bits never reach a core, whatever software wrote
        state_next.applied.gain[0] = state_reg.gain[0][GAIN_FIELD_MSB:0];  // R04
        state_next.applied.gain[1] = state_reg.gain[1][GAIN_FIELD_MSB:0];  // R04
        state_next.applied.gain[2] = core2_pair_b_sel_in ?
                                     state_reg.gain[3][GAIN_FIELD_MSB:0] :
                                     state_reg.gain[2][GAIN_FIELD_MSB:0];  // R05
        state_next.applied.gain[3] = core3_pair_d_sel_in ?
                                     state_reg.gain[5][GAIN_FIELD_MSB:0] :
                                     state_reg.gain[4][GAIN_FIELD_MSB:0];  // R06
    end

    // state register; reset gives plain zeros until the fuse copy runs
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg         <= '0;
            state_reg.phase   <= PH_LOAD;
            state_reg.ofs     <= {NUM_OFS{OFS_RESET}};
            state_reg.gain    <= {NUM_GAIN{GAIN_RESET}};
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs come straight from flip-flops
    assign rdata_out   = state_reg.rdata;
    assign applied_out = state_reg.applied;

    // ------------------------------------------------------------------ checks
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_b_in);

    // named steps reused by the checks below
    sequence s_run_wr(logic [11:0] a);
        state_reg.phase == PH_RUN && wr_in && addr_in == ADDR_W'(a);
    endsequence

    sequence s_run_rd(logic [11:0] a);
        state_reg.phase == PH_RUN && rd_in && addr_in == ADDR_W'(a);
    endsequence

    // core4 offset reaches its core two edges after the write
    a_core4_offset_apply: assert property (  // R01
        s_run_wr(ADDR_OFFSET_TRIM_CORE4) |-> ##2
            applied_out.ofs[1] == $past(wdata_in[OFS_FIELD_MSB:0], 2))
        else $error("core4 offset trim not applied");

    // core3 offset for pair d used while pair d is sampled
    a_core3_offset_pair: assert property (  // R02
        s_run_wr(ADDR_OFFSET_TRIM_CORE3_PAIR_D) ##1 core3_pair_d_sel_in |=>
            applied_out.ofs[0] == $past(wdata_in[OFS_FIELD_MSB:0], 2))
        else $error("core3 pair d offset not selected");

    // core1 gain reaches its core, reserved bits stripped
    a_core1_gain_apply: assert property (  // R04
        s_run_wr(ADDR_FINE_GAIN_CORE_ONE) |-> ##2
            applied_out.gain[1] == $past(wdata_in[GAIN_FIELD_MSB:0], 2))
        else $error("core1 gain trim not applied");

    // core2 gain for pair b used while pair b is sampled
    a_core2_gain_pair: assert property (  // R05
        s_run_wr(ADDR_FINE_GAIN_CORE_TWO_PAIR_B) ##1 core2_pair_b_sel_in |=>
            applied_out.gain[2] == $past(wdata_in[GAIN_FIELD_MSB:0], 2))
        else $error("core2 pair b gain not selected");

    // core3 gain for pair c used while pair c is sampled
    a_core3_gain_pair: assert property (  // R06
        s_run_wr(ADDR_FINE_GAIN_CORE_THREE_PAIR_C) ##1 !core3_pair_d_sel_in |=>
            applied_out.gain[3] == $past(wdata_in[GAIN_FIELD_MSB:0], 2))
        else $error("core3 pair c gain not selected");

    // load phase copies fuse values and leaves reserved bits clear
    a_fuse_default_load: assert property (  // R07
        rst_b_in && state_reg.phase == PH_LOAD |=>
            state_reg.phase == PH_RUN &&
            state_reg.ofs[2] == {4'h0, $past(fuse_in.ofs[2])} &&
            state_reg.gain[5] == {3'h0, $past(fuse_in.gain[5])})
        else $error("fuse defaults not loaded");

    // core5 offset applied as the plain unsigned field
    a_core5_unsigned: assert property (  // R08
        state_reg.phase == PH_RUN ##1 state_reg.phase == PH_RUN |->
            applied_out.ofs[2] == $past(state_reg.ofs[3][OFS_FIELD_MSB:0]))
        else $error("core5 offset not applied unsigned");

    // write then read back with no reset in between
    a_write_readback: assert property (  // R10
        s_run_wr(ADDR_OFFSET_TRIM_CORE3_PAIR_C) ##1
            s_run_rd(ADDR_OFFSET_TRIM_CORE3_PAIR_C) |=>
            rdata_out == $past(wdata_in, 2))
        else $error("offset trim write not visible");

    // read data stands only in the cycle after a read
    a_rdata_one_cycle: assert property (
        !rd_in |=> rdata_out == '0)
        else $error("read data held past its cycle");

    // core0 gain reaches its core two edges after the write
    a_core0_gain_apply: assert property (  // R04
        s_run_wr(ADDR_FINE_GAIN_CORE_ZERO) |-> ##2
            applied_out.gain[0] == $past(wdata_in[GAIN_FIELD_MSB:0], 2))
        else $error("core0 gain trim not applied");

    // core3 offset for pair c used while pair c is sampled
    a_core3_offset_pair_c: assert property (  // R02
        s_run_wr(ADDR_OFFSET_TRIM_CORE3_PAIR_C) ##1 !core3_pair_d_sel_in |=>
            applied_out.ofs[0] == $past(wdata_in[OFS_FIELD_MSB:0], 2))
        else $error("core3 pair c offset not selected");

    // core2 gain for pair a used while pair a is sampled
    a_core2_gain_pair_a: assert property (  // R05
        s_run_wr(ADDR_FINE_GAIN_CORE_TWO_PAIR_A) ##1 !core2_pair_b_sel_in |=>
            applied_out.gain[2] == $past(wdata_in[GAIN_FIELD_MSB:0], 2))
        else $error("core2 pair a gain not selected");

    // core3 gain for pair d used while pair d is sampled
    a_core3_gain_pair_d: assert property (  // R06
        s_run_wr(ADDR_FINE_GAIN_CORE_THREE_PAIR_D) ##1 core3_pair_d_sel_in |=>
            applied_out.gain[3] == $past(wdata_in[GAIN_FIELD_MSB:0], 2))
        else $error("core3 pair d gain not selected");

    // the fuse copy runs once per reset; normal run never falls back to it
    a_load_runs_once: assert property (  // R07
        state_reg.phase == PH_RUN |=> state_reg.phase == PH_RUN)
        else $error("fuse load repeated without reset");

    // core4 offset storage only changes when software writes it
    a_core4_offset_hold: assert property (  // R10
        state_reg.phase == PH_RUN &&
            !(wr_in && dec.ofs_hit && dec.idx == 3'h2) |=>
            $stable(state_reg.ofs[2]))
        else $error("core4 offset changed without a write");

    // a write to no trim slot leaves every trim untouched
    a_unmapped_write: assert property (
        state_reg.phase == PH_RUN && wr_in && !dec.ofs_hit && !dec.gain_hit |=>
            $stable(state_reg.ofs) && $stable(state_reg.gain))
        else $error("unmapped write changed a trim");

    // gain registers are 8 bits wide, upper read byte is zero
    a_gain_read_upper: assert property (
        state_reg.phase == PH_RUN && rd_in && dec.gain_hit |=>
            rdata_out[15:8] == 8'h00)
        else $error("gain read upper byte not zero");

    // status read shows load done and both pair selects
    a_status_read: assert property (
        s_run_rd(ADDR_TRIM_STATUS) |=>
            rdata_out[STAT_LOADED_BIT] == 1'b1 &&
            rdata_out[STAT_SEL2_BIT] == $past(core2_pair_b_sel_in) &&
            rdata_out[STAT_SEL3_BIT] == $past(core3_pair_d_sel_in))
        else $error("status read wrong");

    // a select change alone moves core2 gain within one edge
    a_core2_select_only: assert property (  // R05
        state_reg.phase == PH_RUN && !wr_in ##1 state_reg.phase == PH_RUN |->
            applied_out.gain[2] == ($past(core2_pair_b_sel_in) ?
                $past(state_reg.gain[3][GAIN_FIELD_MSB:0]) :
                $past(state_reg.gain[2][GAIN_FIELD_MSB:0])))
        else $error("core2 gain select not followed");

    // a select change alone moves core3 offset within one edge
    a_core3_select_only: assert property (  // R02
        state_reg.phase == PH_RUN ##1 state_reg.phase == PH_RUN |->
            applied_out.ofs[0] == ($past(core3_pair_d_sel_in) ?
                $past(state_reg.ofs[1][OFS_FIELD_MSB:0]) :
                $past(state_reg.ofs[0][OFS_FIELD_MSB:0])))
        else $error("core3 offset select not followed");

    // core1 and core0 gains ignore the pair selects
    a_gain_no_select: assert property (  // R04
        state_reg.phase == PH_RUN ##1 state_reg.phase == PH_RUN |->
            applied_out.gain[1] == $past(state_reg.gain[1][GAIN_FIELD_MSB:0]) &&
            applied_out.gain[0] == $past(state_reg.gain[0][GAIN_FIELD_MSB:0]))
        else $error("fixed core gain not applied");

endmodule // core_offset_gain_trim_regs

// file: sim/core_offset_gain_trim_regs_test.sv
// core_offset_gain_trim_regs_test: self-checking bench for the trim register bank.
// assumes trim_regs_pkg is compiled first; the bench drives every design port itself.
`timescale 1ns/1ps

module core_offset_gain_trim_regs_test;
    import trim_regs_pkg::*;

    logic                 clk_sys_in;          // 200 MHz system clock
    logic                 rst_b_in;            // async reset, active low
    logic [ADDR_BITS-1:0] addr_in;             // register address
    logic [DATA_BITS-1:0] wdata_in;            // write data
    logic                 wr_in;               // write strobe
    logic                 rd_in;               // read strobe
    logic [DATA_BITS-1:0] rdata_out;           // read data
    fuse_trim_t           fuse_in;             // fuse defaults
    logic                 core2_pair_b_sel_in; // core2 pair select
    logic                 core3_pair_d_sel_in; // core3 pair select
    applied_trim_t        applied_out;         // applied trims
    int                   num_errors = 0;      // mismatches seen
    int                   samples_checked = 0; // comparisons made
    logic [11:0]          ofs_tab [4];         // expected offset trims, fuse order
    logic [4:0]           gain_tab [6];        // expected gain trims, fuse order
    logic [11:0]          addr_tab [10];       // register addresses, same order
    logic [15:0]          rd_val;              // last value read
    logic [11:0]          ofs_new [4];         // offset values about to be written
    logic [4:0]           gain_new [6];        // gain values about to be written

    core_offset_gain_trim_regs #(.ADDR_W(ADDR_BITS)) core_offset_gain_trim_regs_inst (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .fuse_in(fuse_in), .core2_pair_b_sel_in(core2_pair_b_sel_in),
        .core3_pair_d_sel_in(core3_pair_d_sel_in), .applied_out(applied_out));

    // free-running clock, 5 ns period
    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end

    // one comparison; case inequality so unknowns never pass
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // single-cycle write strobe, lowered at the edge that stores it
    task automatic reg_write(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe edge
    task automatic reg_read(input logic [11:0] a, output logic [15:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1;
        d = rdata_out;
    endtask

    // what the cores should see for the tables and current pair selects
    function automatic applied_trim_t exp_applied();
        applied_trim_t t;
        t.ofs[0] = core3_pair_d_sel_in ? ofs_tab[1] : ofs_tab[0];
        t.ofs[1] = ofs_tab[2];
        t.ofs[2] = ofs_tab[3];
        t.gain[0] = gain_tab[0];
        t.gain[1] = gain_tab[1];
        t.gain[2] = core2_pair_b_sel_in ? gain_tab[3] : gain_tab[2];
        t.gain[3] = core3_pair_d_sel_in ? gain_tab[5] : gain_tab[4];
        return t;
    endfunction

    // expected readback; reserved bits are always written as zero here
    function automatic logic [15:0] exp_reg(input int i);
        return (i < 4) ? {4'h0, ofs_tab[i]} : {11'h000, gain_tab[i-4]};
    endfunction

    // read every trim register and compare with the tables
    task automatic check_all();
        for (int i = 0; i < 10; i++) begin
            reg_read(addr_tab[i], rd_val);
            check(rd_val, exp_reg(i));
        end
    endtask

    // present the tables as fuse contents
    task automatic set_fuse();
        for (int i = 0; i < 4; i++) fuse_in.ofs[i] <= ofs_tab[i];
        for (int i = 0; i < 6; i++) fuse_in.gain[i] <= gain_tab[i];
    endtask

    // verdict, reached from the main sequence or the watchdog
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // watchdog: the tests need about 150 cycles
    initial begin
        repeat (5000) @(posedge clk_sys_in);
        num_errors++;
        conclude();
    end

    // main sequence; offset trims touched only while no offset calibration runs
    initial begin
        rst_b_in = 1'b0;
        addr_in = '0;
        wdata_in = '0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        core2_pair_b_sel_in = 1'b0;
        core3_pair_d_sel_in = 1'b0;
        addr_tab = '{ADDR_OFFSET_TRIM_CORE3_PAIR_C, ADDR_OFFSET_TRIM_CORE3_PAIR_D,
                     ADDR_OFFSET_TRIM_CORE4, ADDR_OFFSET_TRIM_CORE5,
                     ADDR_FINE_GAIN_CORE_ZERO, ADDR_FINE_GAIN_CORE_ONE,
                     ADDR_FINE_GAIN_CORE_TWO_PAIR_A, ADDR_FINE_GAIN_CORE_TWO_PAIR_B,
                     ADDR_FINE_GAIN_CORE_THREE_PAIR_C, ADDR_FINE_GAIN_CORE_THREE_PAIR_D};
        ofs_tab = '{12'h123, 12'h456, 12'h789, 12'habc};
        gain_tab = '{5'h01, 5'h0a, 5'h13, 5'h1c, 5'h05, 5'h1f};
        fuse_in = '0;
        set_fuse();
        #3;
        check(applied_out, 64'h0);
        repeat (2) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        #1;
        check(applied_out, exp_applied());
        check_all();
        $display("test fuse defaults finished");
        // boundary values, reserved bits zero; each takes effect two edges on
        ofs_new = '{12'hfff, 12'h000, 12'h800, 12'h7ff};
        gain_new = '{5'h1f, 5'h00, 5'h10, 5'h0f, 5'h15, 5'h0a};
        for (int i = 0; i < 10; i++) begin
            // tables follow storage one register at a time
            if (i < 4) ofs_tab[i] = ofs_new[i];
            else gain_tab[i-4] = gain_new[i-4];
            reg_write(addr_tab[i], exp_reg(i));
            @(posedge clk_sys_in);
            #1;
            check(applied_out, exp_applied());
        end
        check_all();
        $display("test write readback finished");
        // every pair-select combination, one edge to reach the cores
        for (int s = 1; s < 5; s++) begin
            @(posedge clk_sys_in);
            core2_pair_b_sel_in <= s[0];
            core3_pair_d_sel_in <= s[1];
            @(posedge clk_sys_in);
            #1;
            check(applied_out, exp_applied());
        end
        $display("test pair selects finished");
        // alternate pairs selected: writes to them, a read right behind a write
        @(posedge clk_sys_in);
        core2_pair_b_sel_in <= 1'b1;
        core3_pair_d_sel_in <= 1'b1;
        ofs_tab[1] = 12'h3c5;
        gain_tab[3] = 5'h19;
        gain_tab[5] = 5'h06;
        ofs_tab[0] = 12'h9e1;
        reg_write(ADDR_OFFSET_TRIM_CORE3_PAIR_D, exp_reg(1));
        reg_write(ADDR_FINE_GAIN_CORE_TWO_PAIR_B, exp_reg(7));
        reg_write(ADDR_FINE_GAIN_CORE_THREE_PAIR_D, exp_reg(9));
        @(posedge clk_sys_in);
        addr_in <= ADDR_OFFSET_TRIM_CORE3_PAIR_C;
        wdata_in <= exp_reg(0);
        wr_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
        rd_in <= 1'b1;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1;
        check(rdata_out, exp_reg(0));
        check(applied_out, exp_applied());
        // status: load done, core2 pair b and core3 pair d selected
        reg_read(ADDR_TRIM_STATUS, rd_val);
        check(rd_val, 16'h0007);
        $display("test alternate pairs finished");
        // unmapped addresses: writes dropped, reads give zero
        reg_write(12'h366, 16'h001f);
        reg_write(12'h33f, 16'h0aaa);
        reg_read(12'h366, rd_val);
        check(rd_val, 16'h0000);
        check_all();
        $display("test unmapped access finished");
        // mid-run reset reloads the new fuse contents
        ofs_tab = '{12'h5a5, 12'ha5a, 12'h00f, 12'hf00};
        gain_tab = '{5'h11, 5'h02, 5'h1e, 5'h07, 5'h18, 5'h03};
        @(posedge clk_sys_in);
        rst_b_in <= 1'b0;
        set_fuse();
        @(posedge clk_sys_in);
        #1;
        check(applied_out, 64'h0);
        @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        #1;
        check(applied_out, exp_applied());
        check_all();
        $display("test second reset finished");
        conclude();
    end
endmodule // core_offset_gain_trim_regs_test
